// [jtf_pkg.sv]
// Constants, types and helper functions for the transmit framer.
// Assumes a single device clock and transport modes taken from a fixed table.
package jtf_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int LANES = 8;
  localparam int CONVS = 4;
  localparam int SMP_W = 16;
  localparam int SUBCLASS = 1;

  // ****************************************
  // Control characters and headers
  // ****************************************
  localparam logic [7:0] K_COMMA = 8'hbc;
  localparam logic [7:0] K_R = 8'h1c;
  localparam logic [7:0] K_A = 8'h7c;
  localparam logic [7:0] K_Q = 8'h9c;
  localparam logic [7:0] K_F = 8'hfc;
  localparam logic [1:0] SH_DATA = 2'b01;

  // ****************************************
  // Multiframe, block and alignment timing
  // ****************************************
  localparam logic [7:0] MF_LAST_8B = 8'h1f;
  localparam logic [7:0] MF_LAST_64B = 8'hff;
  localparam logic [2:0] BLOCK_FIRST = 3'h0;
  localparam logic [1:0] ILAS_MF_LAST = 2'h3;
  localparam logic [1:0] ILAS_CFG_MF = 2'h1;
  localparam logic [7:0] ILAS_Q_POS = 8'h01;
  localparam logic [7:0] ILAS_CFG_POS = 8'h02;

  // ****************************************
  // Scramblers
  // ****************************************
  localparam int SCR8_TAP_A = 14;
  localparam int SCR8_TAP_B = 13;
  localparam int SCR64_TAP_A = 57;
  localparam int SCR64_TAP_B = 38;
  localparam logic [14:0] SCR8_SEED = 15'h7fff;
  localparam logic [57:0] SCR64_SEED = 58'h3ff_ffff_ffff_ffff;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic enc64;
    logic [1:0] log2f;
    logic [1:0] fmask;
    logic [7:0] lane_mask;
  } mode_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CGS = 3'b001,
    ST_WAIT = 3'b010,
    ST_ILAS = 3'b011,
    ST_DATA = 3'b100
  } link_state_type;

  typedef struct packed {
    logic hdr_valid;
    logic [1:0] hdr;
    logic ctrl;
    logic [7:0] octet;
  } lane_sym_type;

  localparam mode_type MODE_RESET = '{1'b0, 2'h0, 2'h0, 8'hff};

  // Predefined transport modes; unknown selections fall back to mode 0.
  function automatic mode_type mode_lookup(input logic [2:0] sel);
    mode_type m;
    m = MODE_RESET;
    case (sel)
      3'h1: m = '{1'b0, 2'h1, 2'h1, 8'h0f};
      3'h2: m = '{1'b0, 2'h2, 2'h3, 8'h03};
      3'h3: m = '{1'b1, 2'h0, 2'h0, 8'hff};
      3'h4: m = '{1'b1, 2'h1, 2'h1, 8'h0f};
      3'h5: m = '{1'b1, 2'h2, 2'h3, 8'h03};
      default: m = MODE_RESET;
    endcase
    return m;
  endfunction

  // Self-synchronous 1 + x^14 + x^15 scrambler, one octet, MSB first.
  function automatic logic [22:0] scr8_octet(input logic [14:0] st, input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] o;
    logic b;
    s = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ s[SCR8_TAP_A] ^ s[SCR8_TAP_B];
      o[i] = b;
      s = {s[13:0], b};
    end
    return {s, o};
  endfunction

  // Self-synchronous 1 + x^39 + x^58 scrambler, one octet, MSB first.
  function automatic logic [65:0] scr64_octet(input logic [57:0] st, input logic [7:0] d);
    logic [57:0] s;
    logic [7:0] o;
    logic b;
    s = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ s[SCR64_TAP_A] ^ s[SCR64_TAP_B];
      o[i] = b;
      s = {s[56:0], b};
    end
    return {s, o};
  endfunction

endpackage

// [jtf_framer.sv]
// Transmit framer: transport mapping, scrambling and link layer for up to eight lanes.
// Assumes samples are synchronous to MCLK and held for a whole frame, and that
// a downstream character or block encoder and serializer run on the same clock.
//
// Behaviour
// - At most eight lanes carry sample octets; unused lanes stay zero.
// - Each lane runs 8b/10b character or 64b/66b block framing by mode.
// - 8b/10b output keeps JESD204B character framing and control characters.
// - In 64b/66b the SYNC pin is ignored; sync headers give block alignment.
// - SYNC low in 8b/10b starts code group synchronization.
// - Captured SYSREF edge resets the multiframe or multiblock counter to zero.
// - One device clock runs all the logic and lane outputs.
// - Samples become octets, F octets per frame, mapped over L lanes.
// - Lane count and octets per frame come from one selected transport mode.
// - Scrambling optional in 8b/10b, always on in 64b/66b.
// - Scrambling acts on octets before coding and before header insertion.
// - The initial lane alignment sequence is never scrambled.
// - Different self-synchronous polynomials for the two coding schemes.
// - FEC_ENABLE in 64b/66b modes only raises FEC_ACTIVE; no FEC coding is applied.
// - No three-bit CRC in the sync header stream.
// - No command channel in the sync header stream.
// - Subclass 1 deterministic latency only, via SYSREF.
// - All lanes share one counter and state so they align at the receiver.
// - SYNC is acted on at once, suiting older and current receivers.
// - Frames group into multiframes, or into blocks and multiblocks.
// - Link sets boundaries, initialises, codes data and marks alignment.
// - Commas are sent while SYNC is low.
// - ILAS starts on the LMFC edge after SYNC rises and spans four multiframes.
// - Each 64-bit block is preceded by a two-bit sync header.
`timescale 1ns/100ps

module jtf_framer (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Link control
  input wire logic LINK_ENABLE,
  input wire logic [2:0] TRANSPORT_MODE_SELECT,
  input wire logic SCRAMBLE_ENABLE,
  input wire logic FEC_ENABLE,
  input wire logic SYSREF,
  input wire logic LINK_SYNC_PIN_N,
  // Samples
  input wire logic [jtf_pkg::CONVS-1:0][jtf_pkg::SMP_W-1:0] SAMPLE_IN,
  output logic SAMPLE_TAKEN,
  // Lanes
  output jtf_pkg::lane_sym_type [jtf_pkg::LANES-1:0] LANE_OUT,
  output logic [jtf_pkg::LANES-1:0] LANE_ACTIVE,
  // Status
  output jtf_pkg::link_state_type LINK_STATE,
  output logic FEC_ACTIVE
);

  // ****************************************
  // Configuration
  // ****************************************
  jtf_pkg::mode_type cfg_q;
  logic [2:0] mode_sel_q;
  logic scr_en_q;
  logic fec_q;

  // Settings are only taken while the link is disabled.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_q <= jtf_pkg::MODE_RESET;
      mode_sel_q <= 3'h0;
      scr_en_q <= 1'b0;
      fec_q <= 1'b0;
    end else if (!LINK_ENABLE) begin
      cfg_q <= jtf_pkg::mode_lookup(TRANSPORT_MODE_SELECT);
      mode_sel_q <= TRANSPORT_MODE_SELECT;
      scr_en_q <= SCRAMBLE_ENABLE;
      fec_q <= FEC_ENABLE;
    end
  end

  // ****************************************
  // SYSREF and multiframe counter
  // ****************************************
  logic sysref_q;
  logic sysref_edge;
  logic [7:0] mf_cnt_q;
  logic [7:0] mf_last;
  logic [1:0] pos;
  logic frame_end;
  logic mf_end;

  assign sysref_edge = SYSREF & ~sysref_q;
  assign mf_last = cfg_q.enc64 ? jtf_pkg::MF_LAST_64B : jtf_pkg::MF_LAST_8B;
  assign pos = mf_cnt_q[1:0] & cfg_q.fmask;
  assign frame_end = (pos == cfg_q.fmask);
  assign mf_end = (mf_cnt_q == mf_last);

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= SYSREF;
    end
  end

  // One counter serves every lane, so lanes stay mutually aligned.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mf_cnt_q <= 8'h00;
    end else if (sysref_edge) begin
      mf_cnt_q <= 8'h00;
    end else if (mf_end) begin
      mf_cnt_q <= 8'h00;
    end else begin
      mf_cnt_q <= 8'(mf_cnt_q + 8'h01);
    end
  end

  // ****************************************
  // Link state machine
  // ****************************************
  jtf_pkg::link_state_type st_q;
  logic [1:0] ilas_mf_q;

  // SYNC is acted on in the cycle it is seen, with no minimum low time.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= jtf_pkg::ST_IDLE;
    end else if (!LINK_ENABLE) begin
      st_q <= jtf_pkg::ST_IDLE;
    end else if (cfg_q.enc64) begin
      st_q <= jtf_pkg::ST_DATA;
    end else if (!LINK_SYNC_PIN_N) begin
      st_q <= jtf_pkg::ST_CGS;
    end else begin
      case (st_q)
        jtf_pkg::ST_CGS: begin
          st_q <= jtf_pkg::ST_WAIT;
        end
        jtf_pkg::ST_WAIT: begin
          if (mf_end) begin
            st_q <= jtf_pkg::ST_ILAS;
          end
        end
        jtf_pkg::ST_ILAS: begin
          if (mf_end && ilas_mf_q == jtf_pkg::ILAS_MF_LAST) begin
            st_q <= jtf_pkg::ST_DATA;
          end
        end
        default: begin
          st_q <= st_q;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ilas_mf_q <= 2'h0;
    end else if (st_q != jtf_pkg::ST_ILAS) begin
      ilas_mf_q <= 2'h0;
    end else if (mf_end) begin
      ilas_mf_q <= 2'(ilas_mf_q + 2'h1);
    end
  end

  // ****************************************
  // Sample capture
  // ****************************************
  logic [jtf_pkg::CONVS-1:0][jtf_pkg::SMP_W-1:0] hold_q;

  // The sample set is captured at each frame end and sent in the next frame.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_q <= '0;
      SAMPLE_TAKEN <= 1'b0;
    end else begin
      SAMPLE_TAKEN <= frame_end;
      if (frame_end) begin
        hold_q <= SAMPLE_IN;
      end
    end
  end

  // ****************************************
  // Lane symbol generation
  // ****************************************
  logic [14:0] scr8_q [jtf_pkg::LANES];
  logic [57:0] scr64_q [jtf_pkg::LANES];
  logic [7:0] prev_q [jtf_pkg::LANES];
  logic [14:0] scr8_d [jtf_pkg::LANES];
  logic [57:0] scr64_d [jtf_pkg::LANES];
  logic [7:0] prev_d [jtf_pkg::LANES];
  jtf_pkg::lane_sym_type [jtf_pkg::LANES-1:0] sym_d;

  always_comb begin
    logic [2:0] k;
    logic [15:0] smp;
    logic [7:0] raw;
    logic [22:0] r8;
    logic [65:0] r64;
    k = 3'h0;
    smp = 16'h0000;
    raw = 8'h00;
    r8 = '0;
    r64 = '0;
    sym_d = '0;
    for (int l = 0; l < jtf_pkg::LANES; l++) begin
      scr8_d[l] = scr8_q[l];
      scr64_d[l] = scr64_q[l];
      prev_d[l] = prev_q[l];
      // Lane l carries frame octets l*F to l*F+F-1.
      k = (3'(l) << cfg_q.log2f) | {1'b0, pos};
      smp = hold_q[k[2:1]];
      raw = k[0] ? smp[7:0] : smp[15:8];
      r8 = jtf_pkg::scr8_octet(scr8_q[l], raw);
      r64 = jtf_pkg::scr64_octet(scr64_q[l], raw);
      if (cfg_q.lane_mask[l]) begin
        case (st_q)
          jtf_pkg::ST_CGS, jtf_pkg::ST_WAIT: begin
            sym_d[l].ctrl = 1'b1;
            sym_d[l].octet = jtf_pkg::K_COMMA;
          end
          jtf_pkg::ST_ILAS: begin
            // Alignment sequence bypasses the scrambler.
            if (mf_cnt_q == 8'h00) begin
              sym_d[l].ctrl = 1'b1;
              sym_d[l].octet = jtf_pkg::K_R;
            end else if (mf_end) begin
              sym_d[l].ctrl = 1'b1;
              sym_d[l].octet = jtf_pkg::K_A;
            end else if (ilas_mf_q == jtf_pkg::ILAS_CFG_MF && mf_cnt_q == jtf_pkg::ILAS_Q_POS) begin
              sym_d[l].ctrl = 1'b1;
              sym_d[l].octet = jtf_pkg::K_Q;
            end else if (ilas_mf_q == jtf_pkg::ILAS_CFG_MF && mf_cnt_q == jtf_pkg::ILAS_CFG_POS) begin
              sym_d[l].octet = 8'(mode_sel_q);
            end else begin
              sym_d[l].octet = mf_cnt_q;
            end
          end
          jtf_pkg::ST_DATA: begin
            if (cfg_q.enc64) begin
              // Block scrambling is always on, ahead of the header.
              sym_d[l].octet = r64[7:0];
              scr64_d[l] = r64[65:8];
              // Header marks each block start; CRC and command bits are absent.
              sym_d[l].hdr_valid = (mf_cnt_q[2:0] == jtf_pkg::BLOCK_FIRST);
              sym_d[l].hdr = jtf_pkg::SH_DATA;
            end else if (scr_en_q) begin
              sym_d[l].octet = r8[7:0];
              scr8_d[l] = r8[22:8];
              // Scrambled end octets equal to a marker go out as that marker.
              if (mf_end && r8[7:0] == jtf_pkg::K_A) begin
                sym_d[l].ctrl = 1'b1;
              end else if (frame_end && r8[7:0] == jtf_pkg::K_F) begin
                sym_d[l].ctrl = 1'b1;
              end
            end else begin
              sym_d[l].octet = raw;
              // A repeated frame-end octet is replaced by an alignment marker.
              if (frame_end) begin
                prev_d[l] = raw;
                if (raw == prev_q[l]) begin
                  sym_d[l].ctrl = 1'b1;
                  sym_d[l].octet = mf_end ? jtf_pkg::K_A : jtf_pkg::K_F;
                end
              end
            end
          end
          default: begin
            sym_d[l] = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int l = 0; l < jtf_pkg::LANES; l++) begin
        scr8_q[l] <= jtf_pkg::SCR8_SEED;
        scr64_q[l] <= jtf_pkg::SCR64_SEED;
        prev_q[l] <= 8'h00;
      end
    end else begin
      for (int l = 0; l < jtf_pkg::LANES; l++) begin
        scr8_q[l] <= scr8_d[l];
        scr64_q[l] <= scr64_d[l];
        prev_q[l] <= prev_d[l];
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LANE_OUT <= '0;
      LANE_ACTIVE <= 8'h00;
      LINK_STATE <= jtf_pkg::ST_IDLE;
      FEC_ACTIVE <= 1'b0;
    end else begin
      LANE_OUT <= sym_d;
      LANE_ACTIVE <= cfg_q.lane_mask;
      LINK_STATE <= st_q;
      FEC_ACTIVE <= cfg_q.enc64 & fec_q & LINK_ENABLE;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  sync_low_cgs_a: assert property (LINK_ENABLE && !cfg_q.enc64 && !LINK_SYNC_PIN_N |=> st_q == jtf_pkg::ST_CGS) else $error("SYNC low did not start CGS");
  comma_out_a: assert property (st_q == jtf_pkg::ST_CGS |=> LANE_OUT[0].ctrl && LANE_OUT[0].octet == jtf_pkg::K_COMMA) else $error("no comma during CGS");
  sysref_zero_a: assert property (sysref_edge |=> mf_cnt_q == 8'h00) else $error("SYSREF did not reset counter");
  ilas_edge_a: assert property ($rose(st_q == jtf_pkg::ST_ILAS) |-> mf_cnt_q == 8'h00 && $past(st_q) == jtf_pkg::ST_WAIT) else $error("ILAS off LMFC edge");
  ilas_plain_a: assert property (st_q == jtf_pkg::ST_ILAS && mf_cnt_q == 8'h00 |=> LANE_OUT[0].octet == jtf_pkg::K_R && LANE_OUT[0].ctrl) else $error("ILAS start not R");
  ilas_four_a: assert property ($rose(st_q == jtf_pkg::ST_DATA) && !cfg_q.enc64 |-> $past(ilas_mf_q) == jtf_pkg::ILAS_MF_LAST) else $error("ILAS not four multiframes");
  ignore_sync_a: assert property (cfg_q.enc64 && LINK_ENABLE && st_q == jtf_pkg::ST_DATA |=> st_q == jtf_pkg::ST_DATA) else $error("SYNC affected 64b link");
  block_hdr_a: assert property (cfg_q.enc64 && st_q == jtf_pkg::ST_DATA && mf_cnt_q[2:0] == jtf_pkg::BLOCK_FIRST |=> LANE_OUT[0].hdr_valid && LANE_OUT[0].hdr == jtf_pkg::SH_DATA) else $error("missing sync header");
  idle_lane_a: assert property (!cfg_q.lane_mask[jtf_pkg::LANES-1] |=> LANE_OUT[jtf_pkg::LANES-1] == '0) else $error("unused lane driven");
  plain_data_a: assert property (st_q == jtf_pkg::ST_DATA && !cfg_q.enc64 && !scr_en_q && !frame_end |=> LANE_OUT[0].ctrl == 1'b0) else $error("control char in data");

  cgs_to_ilas_c: cover property (st_q == jtf_pkg::ST_WAIT ##1 st_q == jtf_pkg::ST_ILAS);
  data_8b_c: cover property (st_q == jtf_pkg::ST_DATA && !cfg_q.enc64 && scr_en_q);
  data_64b_c: cover property (st_q == jtf_pkg::ST_DATA && cfg_q.enc64);
  sysref_c: cover property (sysref_edge && st_q == jtf_pkg::ST_DATA);

endmodule

// [jtf_rx_model.sv]
// Receiver model for the transmit framer: drives the active-low SYNC handshake.
// Assumes lane 0 carries the comma stream and that it shares the framer clock.
`timescale 1ns/100ps

module jtf_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control from the bench
  input wire logic start,
  input wire logic hold_low,
  input wire logic [7:0] release_delay,
  // Link
  input wire jtf_pkg::lane_sym_type lane,
  output logic sync_n
);
  logic sync_q;
  logic [2:0] comma_q;
  logic [7:0] wait_q;

  // ****************************************
  // Handshake
  // ****************************************
  // Holding the line low shows that block alignment never depends on it.
  assign sync_n = sync_q & ~hold_low;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 1'b1;
      comma_q <= 3'h0;
      wait_q <= 8'h00;
    end else if (start) begin
      sync_q <= 1'b0;
      comma_q <= 3'h0;
      wait_q <= 8'h00;
    end else if (!sync_q) begin
      if (comma_q < 3'h4) begin
        comma_q <= (lane.ctrl && lane.octet == jtf_pkg::K_COMMA) ? comma_q + 3'h1 : 3'h0;
      end else if (wait_q < release_delay) begin
        wait_q <= wait_q + 8'h01;
      end else begin
        sync_q <= 1'b1;
      end
    end
  end
endmodule

// [jtf_framer_tb.sv]
// Self-checking bench for the transmit framer with a receiver model on SYNC.
// Assumes the framer and the receiver model run on the one device clock.
`timescale 1ns/100ps

module jtf_framer_tb;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic LINK_ENABLE = 1'b0;
  logic [2:0] TRANSPORT_MODE_SELECT = 3'h0;
  logic SCRAMBLE_ENABLE = 1'b0;
  logic FEC_ENABLE = 1'b0;
  logic SYSREF = 1'b0;
  logic [jtf_pkg::CONVS-1:0][jtf_pkg::SMP_W-1:0] SAMPLE_IN = '0;
  logic sync_n;
  logic sync_start = 1'b0;
  logic sync_hold = 1'b0;
  logic [7:0] sync_delay = 8'h00;
  logic SAMPLE_TAKEN;
  logic FEC_ACTIVE;
  jtf_pkg::lane_sym_type [jtf_pkg::LANES-1:0] LANE_OUT;
  logic [jtf_pkg::LANES-1:0] LANE_ACTIVE;
  jtf_pkg::link_state_type LINK_STATE;
  int fails = 0;
  int check_count = 0;

  always #12.5 MCLK = ~MCLK;

  jtf_framer uut (.MCLK(MCLK), .RESET_N(RESET_N), .LINK_ENABLE(LINK_ENABLE),
    .TRANSPORT_MODE_SELECT(TRANSPORT_MODE_SELECT), .SCRAMBLE_ENABLE(SCRAMBLE_ENABLE),
    .FEC_ENABLE(FEC_ENABLE), .SYSREF(SYSREF), .LINK_SYNC_PIN_N(sync_n),
    .SAMPLE_IN(SAMPLE_IN), .SAMPLE_TAKEN(SAMPLE_TAKEN), .LANE_OUT(LANE_OUT),
    .LANE_ACTIVE(LANE_ACTIVE), .LINK_STATE(LINK_STATE), .FEC_ACTIVE(FEC_ACTIVE));

  jtf_rx_model rx (.clk(MCLK), .rst_n(RESET_N), .start(sync_start), .hold_low(sync_hold),
    .release_delay(sync_delay), .lane(LANE_OUT[0]), .sync_n(sync_n));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] sym(input int l);
    return {7'h00, LANE_OUT[l].ctrl, LANE_OUT[l].octet};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic wait_state(input jtf_pkg::link_state_type st, input int limit);
    int n;
    n = 0;
    while (LINK_STATE !== st && n < limit) begin
      cyc(1);
      n++;
    end
    check("link state", 16'(st), 16'(LINK_STATE));
  endtask

  // Settings change only while the link is down, then SYSREF, then enable.
  task automatic configure(input logic [2:0] mode, input logic scramble_enable, input logic fec);
    @(posedge MCLK);
    LINK_ENABLE <= 1'b0;
    TRANSPORT_MODE_SELECT <= mode;
    SCRAMBLE_ENABLE <= scramble_enable;
    FEC_ENABLE <= fec;
    repeat (3) @(posedge MCLK);
    SYSREF <= 1'b1;
    repeat (2) @(posedge MCLK);
    SYSREF <= 1'b0;
    @(posedge MCLK);
    LINK_ENABLE <= 1'b1;
    #1;
  endtask

  task automatic request_sync();
    @(posedge MCLK);
    sync_start <= 1'b1;
    @(posedge MCLK);
    sync_start <= 1'b0;
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_modes();
    logic [7:0] masks [8];
    masks = '{8'hff, 8'h0f, 8'h03, 8'hff, 8'h0f, 8'h03, 8'hff, 8'hff};
    for (int m = 0; m < 8; m++) begin
      @(posedge MCLK);
      TRANSPORT_MODE_SELECT <= 3'(m);
      cyc(2);
      check("lane mask", {8'h00, masks[m]}, {8'h00, LANE_ACTIVE});
    end
  endtask

  task automatic t_link8();
    int n;
    configure(3'h0, 1'b1, 1'b0);
    request_sync();
    wait_state(jtf_pkg::ST_CGS, 40);
    check("comma", {8'h01, jtf_pkg::K_COMMA}, sym(0));
    n = 0;
    while (sym(0) !== {8'h01, jtf_pkg::K_R} && n < 400) begin
      cyc(1);
      n++;
    end
    for (int m = 0; m < 4; m++) begin
      check("ilas start", {8'h01, jtf_pkg::K_R}, sym(0));
      check("lane align", sym(0), sym(7));
      cyc(1);
      if (m == 1) check("ilas config", {8'h01, jtf_pkg::K_Q}, sym(0));
      cyc(30);
      check("ilas end", {8'h01, jtf_pkg::K_A}, sym(0));
      cyc(1);
    end
    wait_state(jtf_pkg::ST_DATA, 4);
  endtask

  task automatic t_map();
    int n;
    @(posedge MCLK);
    SAMPLE_IN <= {16'h7788, 16'h5566, 16'h3344, 16'h1122};
    sync_delay <= 8'h28;
    configure(3'h2, 1'b0, 1'b0);
    request_sync();
    wait_state(jtf_pkg::ST_DATA, 600);
    n = 0;
    while (sym(0) !== 16'h0011 && n < 16) begin
      cyc(1);
      n++;
    end
    check("lane0 oct0", 16'h0011, sym(0));
    check("lane1 oct0", 16'h0055, sym(1));
    check("unused lane", 16'h0000, sym(2));
    cyc(1);
    check("lane0 oct1", 16'h0022, sym(0));
    check("lane1 oct1", 16'h0066, sym(1));
    cyc(1);
    check("lane0 oct2", 16'h0033, sym(0));
    cyc(1);
    // The first data frame has no earlier frame end to repeat, so it goes out as data.
    check("first frame end", 16'h0044, sym(0));
    cyc(4);
    check("frame end ctrl", {8'h01, jtf_pkg::K_F}, sym(0));
    n = 0;
    repeat (8) begin
      cyc(1);
      n += int'(SAMPLE_TAKEN === 1'b1);
    end
    check("samples per frame", 16'h0002, 16'(n));
  endtask

  task automatic t_scramble();
    logic changed;
    configure(3'h0, 1'b1, 1'b0);
    request_sync();
    wait_state(jtf_pkg::ST_DATA, 600);
    changed = 1'b0;
    repeat (16) begin
      cyc(1);
      changed |= (LANE_OUT[0].octet !== 8'h11);
    end
    check("scrambled data", 16'h0001, {15'h0, changed});
  endtask

  task automatic sysref_phase(input int skew, output int n);
    cyc(skew);
    @(posedge MCLK);
    SYSREF <= 1'b1;
    @(posedge MCLK);
    SYSREF <= 1'b0;
    cyc(20);
    n = 0;
    while (LANE_OUT[0].hdr_valid !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_block64();
    int a;
    int b;
    @(posedge MCLK);
    sync_hold <= 1'b1;
    configure(3'h3, 1'b0, 1'b1);
    wait_state(jtf_pkg::ST_DATA, 8);
    check("fec flag", 16'h0001, {15'h0, FEC_ACTIVE});
    sysref_phase(1, a);
    check("sync header", 16'(jtf_pkg::SH_DATA), 16'(LANE_OUT[0].hdr));
    for (int i = 1; i <= 8; i++) begin
      cyc(1);
      check("header spacing", 16'(i == 8), {15'h0, LANE_OUT[0].hdr_valid});
      check("header align", {15'h0, LANE_OUT[0].hdr_valid}, {15'h0, LANE_OUT[7].hdr_valid});
    end
    sysref_phase(4, b);
    check("sysref phase", 16'(a), 16'(b));
    @(posedge MCLK);
    sync_hold <= 1'b0;
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge MCLK);
    #1;
    check("state in reset", 16'(jtf_pkg::ST_IDLE), 16'(LINK_STATE));
    check("mask in reset", 16'h0000, {8'h00, LANE_ACTIVE});
    @(posedge MCLK);
    RESET_N <= 1'b1;
    cyc(2);
    check("mask after reset", 16'h00ff, {8'h00, LANE_ACTIVE});
    t_modes();
    t_link8();
    t_map();
    t_scramble();
    t_block64();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge MCLK);
    fails++;
    $display("unexpected timeout: expected done, seen running");
    summarize();
  end
endmodule
